/* File: logic/spi_core_pkg.sv */
// Shared constants for the byte-wide serial port core
// Assumes one core clock at 100 MHz and synchronous pin inputs
`default_nettype none
package spi_core_pkg;
  localparam int BYTE_W      = 8;
  localparam int BIT_CNT_W   = 4;
  localparam int HALF_CNT_W  = 4;
  localparam int RX_DEPTH    = 8;
  localparam int DIV_CNT_W   = 7;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [BIT_CNT_W-1:0]  LAST_BIT  = 4'h7;
  localparam logic [HALF_CNT_W-1:0] LAST_HALF = 4'hf;
  localparam logic [BYTE_W-1:0]     BYTE_RST  = 8'h00;

  // Rate select is {doubleSpeed, rate[1:0]}
  typedef enum logic [1:0] {
    MS_IDLE  = 2'b00,
    MS_WAIT  = 2'b01,
    MS_SHIFT = 2'b10
  } master_state_t;

  // Core cycles per half SCK period
  function automatic logic [DIV_CNT_W-1:0] halfPeriod(
    input logic [2:0] sel);
    case (sel)
      3'h0:    halfPeriod = 7'h02;
      3'h1:    halfPeriod = 7'h08;
      3'h2:    halfPeriod = 7'h20;
      3'h3:    halfPeriod = 7'h40;
      3'h4:    halfPeriod = 7'h01;
      3'h5:    halfPeriod = 7'h04;
      3'h6:    halfPeriod = 7'h10;
      default: halfPeriod = 7'h20;
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: logic/rx_byte_fifo.sv */
// Receive FIFO with valid and ready on both sides
// Assumes one clock and asynchronous active-low reset
`default_nettype none
module rx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output var  logic             inReady,
  // Drain side
  output var  logic             outValid,
  output var  logic [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int PW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1)
      $error("rx_byte_fifo: bad WIDTH or DEPTH");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_reg;
  logic [PW-1:0]    rdPtr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  assign inReady  = count_reg != (PW+1)'(DEPTH);
  assign outValid = count_reg != '0;
  assign outData  = mem[rdPtr_reg];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: logic/sck_rate_divider.sv */
// Half-period tick generator for the master serial clock
// Assumes the caller holds run low between transfers
`default_nettype none
module sck_rate_divider
  import spi_core_pkg::*;
#(
  parameter int CNT_W = DIV_CNT_W
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] rateSel,
  // One-cycle enable per half period
  output var  logic       tick
);
  initial begin
    if (CNT_W < DIV_CNT_W)
      $error("sck_rate_divider: CNT_W too small");
  end
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] limit;

  assign limit = CNT_W'(halfPeriod(rateSel)) - 1'b1;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (!run) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (cnt_reg >= limit) begin
      cnt_reg <= '0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick    <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: logic/spi_master_slave_core.sv */
// Byte-wide full-duplex serial port, master or slave
// Assumes pin inputs synchronous to core_clk; pads resolve enables
// Overview of operation
// [RULE1] Master write to shift register starts transfer
// [RULE2] After eight bits clock halts, done flag set
// [RULE3] Done flag with enable raises interrupt request
// [RULE4] Master never drives slave select itself
// [RULE5] Data master-to-slave on MOSI, back on MISO
// [RULE6] Master pulls select low, then clocks data
// [RULE7] Master raises select after each packet
// [RULE8] Master software continues or ends the packet
// [RULE9] Last received byte kept in receive buffer
// [RULE10] Deselected slave idles, MISO off, loads allowed
// [RULE11] Slave ignores SCK until selected
// [RULE12] Slave sets done flag after full byte
// [RULE13] Slave accepts new data before reading received
// [RULE14] Transmit single buffered; no load mid-byte
// [RULE15] Receive double buffered; unread byte overwritten; code queues 8 bytes, master waits and slave drops when full
// [RULE16] Far master keeps SCK low over two cycles
// [RULE17] Far master keeps SCK high over two cycles
// [RULE18] Enabled port overrides pin directions by mode
// [RULE19] Selectable LSB-first or MSB-first order
// [RULE20] Seven master clock rates, fastest divide two
// [RULE21] Completion can wake core from idle
// [RULE22] Slave select rising resets slave shift logic
// [RULE23] Select low in master mode forces slave
// [RULE24] Polarity and phase pick idle and edges
// [RULE25] Write during transfer flags collision only
`default_nettype none
module spi_master_slave_core
  import spi_core_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = RX_DEPTH
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  // Control bits
  input  wire logic              portEnable,
  input  wire logic              transferIrqEnable,
  input  wire logic              lsbFirst,
  input  wire logic              clockPolarity,
  input  wire logic              clockPhase,
  input  wire logic [1:0]        rateSel,
  input  wire logic              doubleSpeed,
  input  wire logic              masterWrite,
  input  wire logic              masterWriteValue,
  input  wire logic              ssIsInput,
  // User pin directions
  input  wire logic              mosiDirOut,
  input  wire logic              misoDirOut,
  input  wire logic              sckDirOut,
  // Shift data register access
  input  wire logic              dataWrite,
  input  wire logic [WIDTH-1:0]  dataIn,
  input  wire logic              doneClear,
  input  wire logic              collisionClear,
  // Status
  output var  logic              masterSelect,
  output var  logic              transferDone,
  output var  logic              writeCollision,
  output var  logic              rxOverrun,
  output var  logic              transferIrq,
  output var  logic              idleWake,
  output var  logic [WIDTH-1:0]  rxBuffer,
  // Received byte stream
  output var  logic              rxValid,
  output var  logic [WIDTH-1:0]  rxData,
  input  wire logic              rxReady,
  // Serial pins
  input  wire logic              mosiIn,
  output var  logic              mosiOut,
  output var  logic              mosiOe_n,
  input  wire logic              misoIn,
  output var  logic              misoOut,
  output var  logic              misoOe_n,
  input  wire logic              sckIn,
  output var  logic              sckOut,
  output var  logic              sckOe_n,
  input  wire logic              ssIn
);
  initial begin
    if (WIDTH != BYTE_W || DEPTH < 2)
      $error("spi_master_slave_core: unsupported WIDTH or DEPTH");
  end

  master_state_t           state_reg;
  logic [WIDTH-1:0]        shift_reg;
  logic [BIT_CNT_W-1:0]    bitCnt_reg;
  logic [HALF_CNT_W-1:0]   halfCnt_reg;
  logic                    pend_reg;
  logic                    inBit_reg;
  logic                    sckLevel_reg;
  logic                    sckPrev_reg;
  logic                    ssPrev_reg;
  logic                    master_reg;
  logic                    done_reg;
  logic                    coll_reg;
  logic                    ovr_reg;
  logic                    irq_reg;
  logic                    wake_reg;
  logic [WIDTH-1:0]        rxBuf_reg;
  logic                    mosi_reg;
  logic                    mosiOe_reg;
  logic                    miso_reg;
  logic                    misoOe_reg;
  logic                    sckOe_reg;
  logic                    tick;
  logic                    fifoReady;
  logic                    isMaster;
  logic                    slaveSel;
  logic                    modeFault;
  logic                    lead;
  logic                    trail;
  logic                    sampleEv;
  logic                    setupEv;
  logic                    inPin;
  logic                    lastSample;
  logic                    masterEnd;
  logic                    doneEv;
  logic                    busy;
  logic                    outBit;
  logic [WIDTH-1:0]        capWord;

  // Shift one bit in at the end chosen by the order bit
  function automatic logic [BYTE_W-1:0] shiftIn(
    input logic [BYTE_W-1:0] cur,
    input logic              b,
    input logic              lsbF);
    shiftIn = lsbF ? {b, cur[BYTE_W-1:1]} : {cur[BYTE_W-2:0], b};
  endfunction

  assign isMaster  = portEnable & master_reg;
  assign slaveSel  = portEnable & !master_reg & !ssIn;  // see [RULE4]
  assign modeFault = isMaster & ssIsInput & !ssIn;      // see [RULE23]
  assign lead  = isMaster
    ? (state_reg == MS_SHIFT) & tick & !halfCnt_reg[0]
    : slaveSel & (sckIn != sckPrev_reg)
      & (sckPrev_reg == clockPolarity);                 // see [RULE11]
  assign trail = isMaster
    ? (state_reg == MS_SHIFT) & tick & halfCnt_reg[0]
    : slaveSel & (sckIn != sckPrev_reg)
      & (sckPrev_reg != clockPolarity);
  assign sampleEv = clockPhase ? trail : lead;          // see [RULE24]
  assign setupEv  = clockPhase ? lead : trail;
  assign inPin    = isMaster ? misoIn : mosiIn;         // see [RULE5]
  assign lastSample = sampleEv & (bitCnt_reg == LAST_BIT);
  assign capWord  = shiftIn(shift_reg, inPin, lsbFirst);
  assign masterEnd = (state_reg == MS_SHIFT) & tick
    & (halfCnt_reg == LAST_HALF);
  assign doneEv = isMaster ? masterEnd : lastSample;    // see [RULE12]
  assign busy = isMaster ? state_reg != MS_IDLE
    : slaveSel & ((bitCnt_reg != '0) | pend_reg);
  assign outBit = lsbFirst ? shift_reg[0]
    : shift_reg[BYTE_W-1];                               // see [RULE19]

  sck_rate_divider u_div (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run      (state_reg == MS_SHIFT),
    .rateSel  ({doubleSpeed, rateSel}),                 // see [RULE20]
    .tick     (tick)
  );

  rx_byte_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .inValid  (lastSample),
    .inData   (capWord),
    .inReady  (fifoReady),
    .outValid (rxValid),
    .outData  (rxData),
    .outReady (rxReady)
  );

  // Master sequencer and serial clock
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= MS_IDLE;
      halfCnt_reg  <= '0;
      sckLevel_reg <= 1'b0;
    end else if (!isMaster || modeFault) begin
      state_reg    <= MS_IDLE;
      halfCnt_reg  <= '0;
      sckLevel_reg <= clockPolarity;
    end else begin
      case (state_reg)
        MS_IDLE: begin
          sckLevel_reg <= clockPolarity;
          halfCnt_reg  <= '0;
          if (dataWrite) begin
            state_reg <= MS_WAIT;                       // see [RULE1]
          end
        end
        MS_WAIT: begin
          if (fifoReady) begin
            state_reg <= MS_SHIFT;                      // see [RULE15]
          end
        end
        MS_SHIFT: begin
          if (tick) begin
            sckLevel_reg <= !sckLevel_reg;
            halfCnt_reg  <= halfCnt_reg + 1'b1;
          end
          if (masterEnd) begin
            state_reg <= MS_IDLE;                       // see [RULE2]
          end
        end
        default: state_reg <= MS_IDLE;
      endcase
    end
  end

  // Shift register, bit count and pin history
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg   <= BYTE_RST;
      bitCnt_reg  <= '0;
      pend_reg    <= 1'b0;
      inBit_reg   <= 1'b0;
      sckPrev_reg <= 1'b0;
      ssPrev_reg  <= 1'b1;
    end else begin
      sckPrev_reg <= sckIn;
      ssPrev_reg  <= ssIn;
      if (!isMaster && !slaveSel) begin
        bitCnt_reg <= '0;                               // see [RULE22]
        pend_reg   <= 1'b0;
      end else if (lastSample) begin
        shift_reg  <= capWord;
        bitCnt_reg <= '0;
        pend_reg   <= 1'b0;
      end else if (sampleEv) begin
        inBit_reg  <= inPin;
        pend_reg   <= 1'b1;
        bitCnt_reg <= bitCnt_reg + 1'b1;
      end else if (setupEv && pend_reg) begin
        shift_reg <= shiftIn(shift_reg, inBit_reg, lsbFirst);
        pend_reg  <= 1'b0;
      end
      if (dataWrite && !busy && !modeFault) begin
        shift_reg <= dataIn;  // see [RULE10] see [RULE13] see [RULE14]
      end
    end
  end

  // Mode bit, flags and receive buffer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      master_reg <= 1'b0;
      done_reg   <= 1'b0;
      coll_reg   <= 1'b0;
      ovr_reg    <= 1'b0;
      irq_reg    <= 1'b0;
      wake_reg   <= 1'b0;
      rxBuf_reg  <= BYTE_RST;
    end else begin
      if (modeFault) begin
        master_reg <= 1'b0;                             // see [RULE23]
      end else if (masterWrite) begin
        master_reg <= masterWriteValue;
      end
      done_reg <= doneEv | modeFault | (done_reg & !doneClear);
      coll_reg <= (dataWrite & busy)
        | (coll_reg & !collisionClear);                 // see [RULE25]
      ovr_reg  <= (lastSample & !fifoReady)
        | (ovr_reg & !doneClear);
      irq_reg  <= done_reg & transferIrqEnable;         // see [RULE3]
      wake_reg <= doneEv | modeFault;                   // see [RULE21]
      if (lastSample) begin
        rxBuf_reg <= capWord;                           // see [RULE9]
      end
    end
  end

  // Registered pin drive and direction override
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mosi_reg   <= 1'b0;
      mosiOe_reg <= 1'b1;
      miso_reg   <= 1'b0;
      misoOe_reg <= 1'b1;
      sckOe_reg  <= 1'b1;
    end else begin
      mosi_reg <= isMaster & outBit;
      miso_reg <= !isMaster & outBit;
      if (!portEnable) begin
        mosiOe_reg <= !mosiDirOut;
        misoOe_reg <= !misoDirOut;
        sckOe_reg  <= !sckDirOut;
      end else if (master_reg) begin
        mosiOe_reg <= !mosiDirOut;                      // see [RULE18]
        misoOe_reg <= 1'b1;
        sckOe_reg  <= !sckDirOut;
      end else begin
        mosiOe_reg <= 1'b1;
        misoOe_reg <= !(misoDirOut & !ssIn);            // see [RULE10]
        sckOe_reg  <= 1'b1;
      end
    end
  end

  assign masterSelect   = master_reg;
  assign transferDone   = done_reg;
  assign writeCollision = coll_reg;
  assign rxOverrun      = ovr_reg;
  assign transferIrq    = irq_reg;
  assign idleWake       = wake_reg;
  assign rxBuffer       = rxBuf_reg;
  assign mosiOut        = mosi_reg;
  assign mosiOe_n       = mosiOe_reg;
  assign misoOut        = miso_reg;
  assign misoOe_n       = misoOe_reg;
  assign sckOut         = sckLevel_reg;
  assign sckOe_n        = sckOe_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_master_start: assert property (        // see [RULE1]
    isMaster && !modeFault && state_reg == MS_IDLE && dataWrite
    |=> state_reg == MS_WAIT)
    else $error("master write did not start transfer");
  a_clock_halt: assert property (          // see [RULE2]
    masterEnd |=> state_reg == MS_IDLE && done_reg)
    else $error("clock not halted or done not set");
  a_irq_request: assert property (         // see [RULE3]
    doneEv && transferIrqEnable && !modeFault |=> ##1 transferIrq)
    else $error("done did not raise interrupt");
  a_slave_idle: assert property (          // see [RULE11]
    portEnable && !master_reg && ssIn |=> bitCnt_reg == '0 && !pend_reg)
    else $error("deselected slave counted bits");
  a_miso_off: assert property (            // see [RULE10]
    portEnable && !master_reg && ssIn |=> misoOe_n)
    else $error("MISO driven while deselected");
  a_master_miso_in: assert property (      // see [RULE18]
    portEnable && master_reg |=> misoOe_n && !miso_reg)
    else $error("MISO not input in master mode");
  a_write_collide: assert property (       // see [RULE25]
    dataWrite && busy |=> writeCollision)
    else $error("collision not flagged");
  a_no_load_busy: assert property (        // see [RULE14]
    dataWrite && busy && !sampleEv && !setupEv && !lastSample
    |=> $stable(shift_reg))
    else $error("write disturbed transfer");
  a_rx_keep: assert property (             // see [RULE9]
    !lastSample |=> $stable(rxBuf_reg))
    else $error("receive buffer changed without byte");
  a_mode_fault: assert property (          // see [RULE23]
    modeFault |=> !master_reg && done_reg && state_reg == MS_IDLE)
    else $error("mode fault not handled");

  c_master_done: cover property (masterEnd);
  c_slave_done: cover property (!isMaster && lastSample);
  c_mode_fault: cover property (modeFault);
  c_collision: cover property (dataWrite && busy);
endmodule
`default_nettype wire

/* File: test/far_spi_peer.sv */
// Far-side serial peer: slave to a master core, master on request
// Assumes core_clk is the bench clock; pins are plain wires
`default_nettype none
module far_spi_peer (
  // Clock
  input  wire logic       core_clk,
  // Settings
  input  wire logic       clock_polarity_bit,
  input  wire logic       clock_phase_bit,
  input  wire logic       lsbF,
  // Slave role
  input  wire logic       selN,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic [7:0] txByte,
  output var  logic       miso,
  output var  logic [7:0] rxByte,
  // Master role
  input  wire logic       dutMiso,
  output var  logic       sckM,
  output var  logic       mosiM,
  output var  logic       ssM
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sckQ;
  logic [2:0] idx;
  logic       lastBit;
  logic       smp;

  function automatic logic [2:0] pos(input logic [2:0] i);
    pos = lsbF ? i : 3'h7 - i;
  endfunction

  initial begin
    sckQ = 1'b0;
    lastBit = 1'b0;
    sckM = 1'b0;
    mosiM = 1'b0;
    ssM = 1'b1;
  end

  // Sample edge is leading for phase 0, trailing for phase 1
  assign smp = (sck != sckQ) && ((sck != clock_polarity_bit) ^ clock_phase_bit);
  always @(posedge core_clk) begin
    sckQ <= sck;
    if (selN) idx <= 3'h0;
    else if (smp) begin
      rxByte[pos(idx)] <= mosi;
      idx <= idx + 3'h1;
    end
  end

  // Deselected line shows the inverse of its last level
  always @(posedge core_clk) if (!selN) lastBit <= miso;
  assign miso = selN ? ~lastBit : txByte[pos(idx)];

  task automatic sendAsMaster(input logic [7:0] b, input int n,
                              output logic [7:0] got);
    got = 8'h00;
    sckM = clock_polarity_bit;
    repeat (4) @(negedge core_clk);
    ssM = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (!clock_phase_bit) mosiM = b[pos(3'(i))];
      repeat (4) @(negedge core_clk);
      sckM = ~clock_polarity_bit;
      if (clock_phase_bit) mosiM = b[pos(3'(i))];
      else got[pos(3'(i))] = dutMiso;
      repeat (4) @(negedge core_clk);
      sckM = clock_polarity_bit;
      if (clock_phase_bit) got[pos(3'(i))] = dutMiso;
    end
    repeat (4) @(negedge core_clk);
    ssM = 1'b1;
    mosiM = ~mosiM;
    repeat (4) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

/* File: test/spi_master_slave_core_bench.sv */
// Self-checking bench for the byte-wide serial port core
// Assumes far_spi_peer stands on the serial pins
`default_nettype none
module spi_master_slave_core_bench
  import spi_core_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk, arst_n, portEnable, transferIrqEnable, lsbFirst;
  logic       clockPolarity, clockPhase, doubleSpeed, masterWrite;
  logic       masterWriteValue, ssIsInput, mosiDirOut, misoDirOut;
  logic       sckDirOut, dataWrite, doneClear, collisionClear, rxReady;
  logic       masterSelect, transferDone, writeCollision, rxOverrun;
  logic       transferIrq, idleWake, rxValid, mosiOut, mosiOe_n, selN;
  logic       misoOut, misoOe_n, sckOut, sckOe_n, peerMiso, sckM;
  logic       mosiM, ssM;
  logic [1:0] rateSel;
  logic [7:0] dataIn, peerTx, peerRx, got, b, rxBuffer, rxData;
  logic [7:0] q[$];
  int         mismatches, comparisons, seed, cnt, wakes, h;
  time        t0;

  spi_master_slave_core dut_u (.core_clk, .arst_n, .portEnable,
    .transferIrqEnable, .lsbFirst, .clockPolarity, .clockPhase, .rateSel,
    .doubleSpeed, .masterWrite, .masterWriteValue, .ssIsInput,
    .mosiDirOut, .misoDirOut, .sckDirOut, .dataWrite, .dataIn, .doneClear,
    .collisionClear, .masterSelect, .transferDone, .writeCollision,
    .rxOverrun, .transferIrq, .idleWake, .rxBuffer, .rxValid, .rxData,
    .rxReady, .mosiIn(mosiM), .mosiOut, .mosiOe_n, .misoIn(peerMiso),
    .misoOut, .misoOe_n, .sckIn(sckM), .sckOut, .sckOe_n, .ssIn(ssM));

  far_spi_peer peer_u (.core_clk, .clock_polarity_bit(clockPolarity), .clock_phase_bit(clockPhase),
    .lsbF(lsbFirst), .selN, .sck(sckOut), .mosi(mosiOut), .txByte(peerTx),
    .miso(peerMiso), .rxByte(peerRx), .dutMiso(misoOut), .sckM, .mosiM,
    .ssM);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask

  task automatic writeByte(input logic [7:0] v);
    dataIn = v;
    pulse(dataWrite);
  endtask

  // Master half period in core cycles from {doubleSpeed, rateSel}
  function automatic int halfOf(input logic [2:0] s);
    if (s[1:0] == 2'h3) halfOf = s[2] ? 32 : 64;
    else halfOf = (s[2] ? 1 : 2) << (2 * s[1:0]);
  endfunction

  task automatic waitDone();
    wakes = 0;
    for (int i = 0; i < 3000 && transferDone !== 1'b1; i++) begin
      @(negedge core_clk);
      if (idleWake === 1'b1) wakes++;
    end
    cnt = int'(($time - t0) / 10);
    repeat (2) begin
      @(negedge core_clk);
      if (idleWake === 1'b1) wakes++;
    end
  endtask

  initial begin
    #300_000;
    mismatches++;
    complete_run();
  end

  initial begin
    {portEnable, transferIrqEnable, lsbFirst, clockPolarity} = 4'h8;
    {clockPhase, doubleSpeed, masterWrite, masterWriteValue} = 4'h0;
    {ssIsInput, dataWrite, doneClear, collisionClear, rxReady} = 5'h00;
    {mosiDirOut, misoDirOut, sckDirOut, selN, rateSel} = 6'h3c;
    {dataIn, arst_n} = 9'h000;
    mismatches = 0;
    comparisons = 0;
    seed = 98299;
    repeat (4) @(negedge core_clk);
    check(16'({mosiOe_n, misoOe_n, sckOe_n, transferDone}), 16'h000e);
    arst_n = 1'b1;
    masterWriteValue = 1'b1;
    pulse(masterWrite);
    for (int k = 0; k < 9; k++) begin
      {doubleSpeed, rateSel} = 3'(k);
      {clockPolarity, clockPhase, lsbFirst} = 3'(k * 3);
      transferIrqEnable = k[0];
      peerTx = 8'($random(seed));
      b = 8'($random(seed));
      selN = 1'b1;
      repeat (3) @(negedge core_clk);
      selN = 1'b0;
      t0 = $time;
      writeByte(b);
      @(negedge core_clk);
      writeByte(~b);
      @(negedge core_clk);
      check(16'(writeCollision), 16'h0001);
      pulse(collisionClear);
      if (k == 8) begin
        repeat (200) @(negedge core_clk);
        check(16'(transferDone), 16'h0000);
        rxReady = 1'b1;
        for (int j = 0; j < 8; j++) begin
          check(16'({rxValid, rxData}), 16'({1'b1, q.pop_front()}));
          @(negedge core_clk);
        end
        rxReady = 1'b0;
        check(16'(rxValid), 16'h0000);
      end
      waitDone();
      h = 16 * halfOf(3'(k));
      check(16'((cnt > h && cnt <= h + 5) || k == 8), 16'h0001);
      check(16'(peerRx), 16'(b));
      check(16'(rxBuffer), 16'(peerTx));
      check(16'(transferIrq), 16'(k[0]));
      check(16'(wakes), 16'h0001);
      check(16'(sckOut), 16'(clockPolarity));
      check(16'({mosiOe_n, misoOe_n, sckOe_n}), 16'h0002);
      q.push_back(peerTx);
      pulse(doneClear);
      selN = k[0];
    end
    selN = 1'b1;
    ssIsInput = 1'b1;
    peer_u.ssM = 1'b0;
    repeat (2) @(negedge core_clk);
    check(16'({masterSelect, transferDone}), 16'h0001);
    peer_u.ssM = 1'b1;
    ssIsInput = 1'b0;
    pulse(doneClear);
    for (int k = 0; k < 5; k++) begin
      {clockPolarity, clockPhase} = 2'(k);
      lsbFirst = 1'($random(seed));
      b = 8'($random(seed));
      peerTx = 8'($random(seed));
      writeByte(b);
      repeat (16) begin
        peer_u.sckM = ~peer_u.sckM;
        repeat (4) @(negedge core_clk);
      end
      check(16'({writeCollision, transferDone}), 16'h0000);
      check(16'({mosiOe_n, misoOe_n, sckOe_n}), 16'h0007);
      if (k == 4) begin
        peer_u.sendAsMaster(~peerTx, 3, got);
        check(16'(transferDone), 16'h0000);
        writeByte(b);
      end
      peer_u.sendAsMaster(peerTx, 8, got);
      check(16'(got), 16'(b));
      check(16'(rxBuffer), 16'(peerTx));
      check(16'(transferDone), 16'h0001);
      pulse(doneClear);
    end
    complete_run();
  end
endmodule
`default_nettype wire
